/* File: pll_divider_control_defines.vh */
// Register map, field layout and reset values of the pixel clock control
`ifndef PLL_DIVIDER_CONTROL_DEFINES_VH
`define PLL_DIVIDER_CONTROL_DEFINES_VH

// Register offsets on the two-wire control port
`define REG_SILICON_REVISION      8'h00
`define REG_DIVIDE_RATIO_UPPER    8'h01
`define REG_DIVIDE_RATIO_LOWER    8'h02
`define REG_CLOCK_GENERATOR_CTRL  8'h03

// Field positions
`define LOWER_NIBBLE_MSB          7
`define LOWER_NIBBLE_LSB          4
`define RANGE_MSB                 7
`define RANGE_LSB                 6
`define CLKGEN_OTHER_MSB          5
`define CLKGEN_OTHER_LSB          2

// Reset values
`define DIVIDE_RATIO_UPPER_RST    8'h69
`define DIVIDE_RATIO_LOWER_RST    4'hD
`define RANGE_RST                 2'h1
`define CLKGEN_OTHER_RST          4'h2

// Oscillator range codes and the post-divider each selects
`define RANGE_12_30               2'h0
`define RANGE_30_60               2'h1
`define RANGE_60_120              2'h2
`define RANGE_120_150             2'h3
`define POST_DIV_BY4              2'h2
`define POST_DIV_BY2              2'h1
`define POST_DIV_BY1              2'h0

// Supported divide ratio limits
`define DIVIDE_RATIO_MIN          12'h0DD
`define DIVIDE_RATIO_MAX          12'hFFF

`endif

/* File: pll_divider_control.v */
// Two-wire register slave and line-locked pixel tick generator
// Functional notes
// - Address 0x00 is a read-only 8-bit silicon revision byte.
// - Address 0x01 holds the upper eight bits of the 12-bit divide ratio.
// - Address 0x02 bits 7:4 hold the lower four bits of the divide ratio.
// - The active ratio changes only on a write to the lower register.
// - Ratios 221 to 4095 are supported and the host programs only those.
// - After reset the active ratio is 1693, upper reads 0x69, nibble D.
// - The pixel tick is divided by the ratio and locked to the line sync.
// - The ratio equals the pixel ticks per line, active plus blanking.
// - A larger ratio gives a proportionally faster tick at fixed sync.
// - Address 0x03 bits 7:6 select the oscillator operating range.
// - The post-divider is derived from the range, slow rates divide more.
// - Range 00..11 map to 12-30, 30-60, 60-120, 120-150; reset is 01.
`timescale 1ns/1ps
`include "pll_divider_control_defines.vh"
`default_nettype none

module pll_divider_control #(
   parameter [6:0] DEVICE_ADDR  = 7'h4C,  // Arbitrary bus address
   parameter [7:0] REVISION     = 8'h00,  // Arbitrary revision value
   parameter       PERIOD_W     = 24
) (
   // Clock and reset
   input  wire                sys_clk_in,
   input  wire                rst_n_in,
   // Two-wire serial control port
   input  wire                scl_in,
   input  wire                sda_in,
   output wire                sda_out,
   output wire                sda_oe_out,
   // Line sync input
   input  wire                hsync_in,
   // Clock generator controls
   output wire [11:0]         line_divide_ratio_out,
   output wire [1:0]          oscillator_range_select_out,
   output wire [1:0]          post_divider_select_out,
   output wire                pixel_tick_out,
   output wire                line_locked_out
);

   // Serial port states
   localparam [3:0] S_IDLE     = 4'h0;
   localparam [3:0] S_ADDR     = 4'h1;
   localparam [3:0] S_ADDR_ACK = 4'h2;
   localparam [3:0] S_SUB      = 4'h3;
   localparam [3:0] S_SUB_ACK  = 4'h4;
   localparam [3:0] S_WR       = 4'h5;
   localparam [3:0] S_WR_ACK   = 4'h6;
   localparam [3:0] S_RD       = 4'h7;
   localparam [3:0] S_RD_ACK   = 4'h8;

   // Pin synchronisers, three stages each
   reg  [2:0]          scl_sync_r;
   reg  [2:0]          sda_sync_r;
   reg  [2:0]          hs_sync_r;
   reg                 scl_f_r;
   reg                 sda_f_r;
   reg                 hs_f_r;
   // Serial port engine
   reg  [3:0]          state_r;
   reg  [3:0]          bit_cnt_r;
   reg  [7:0]          shift_r;
   reg  [7:0]          ptr_r;
   reg                 mack_r;
   reg                 sda_oe_r;
   reg                 sda_out_r;
   reg                 wr_stb_r;
   reg  [7:0]          wr_addr_r;
   reg  [7:0]          wr_data_r;
   // Register file
   reg  [7:0]          upper_stage_r;
   reg  [3:0]          lower_nibble_r;
   reg  [11:0]         ratio_r;
   reg  [1:0]          range_r;
   reg  [3:0]          clkgen_other_r;
   reg  [1:0]          post_div_r;
   // Line lock generator
   reg  [PERIOD_W-1:0] period_cnt_r;
   reg  [PERIOD_W-1:0] line_period_r;
   reg  [PERIOD_W:0]   acc_r;
   reg  [11:0]         tick_cnt_r;
   reg                 tick_r;
   reg                 locked_r;

   wire                scl_rise;
   wire                scl_fall;
   wire                start_cond;
   wire                stop_cond;
   wire                hs_rise;
   wire [PERIOD_W:0]   acc_sum;
   wire [7:0]          rd_byte;

   // Register read decode
   function [7:0] reg_read;
      input [7:0] addr;
      begin
         case (addr)
            `REG_SILICON_REVISION:     reg_read = REVISION;
            `REG_DIVIDE_RATIO_UPPER:   reg_read = upper_stage_r;
            `REG_DIVIDE_RATIO_LOWER:   reg_read = {lower_nibble_r, 4'h0};
            `REG_CLOCK_GENERATOR_CTRL:
               reg_read = {range_r, clkgen_other_r, 2'h0};
            default:                   reg_read = 8'h00;
         endcase
      end
   endfunction

   // Pin synchronisers; a change counts when stages two and three agree
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         scl_sync_r <= 3'h7;
         sda_sync_r <= 3'h7;
         hs_sync_r  <= 3'h0;
         scl_f_r    <= 1'b1;
         sda_f_r    <= 1'b1;
         hs_f_r     <= 1'b0;
      end else begin
         scl_sync_r <= {scl_sync_r[1:0], scl_in};
         sda_sync_r <= {sda_sync_r[1:0], sda_in};
         hs_sync_r  <= {hs_sync_r[1:0], hsync_in};
         if (scl_sync_r[1] == scl_sync_r[2]) scl_f_r <= scl_sync_r[2];
         if (sda_sync_r[1] == sda_sync_r[2]) sda_f_r <= sda_sync_r[2];
         if (hs_sync_r[1] == hs_sync_r[2])   hs_f_r  <= hs_sync_r[2];
      end
   end

   // Edge and bus condition detection on filtered levels
   assign scl_rise   = ~scl_f_r & scl_sync_r[2] & scl_sync_r[1];
   assign scl_fall   = scl_f_r & ~scl_sync_r[2] & ~scl_sync_r[1];
   assign start_cond = scl_f_r & sda_f_r & ~sda_sync_r[2] & ~sda_sync_r[1];
   assign stop_cond  = scl_f_r & ~sda_f_r & sda_sync_r[2] & sda_sync_r[1];
   assign hs_rise    = ~hs_f_r & hs_sync_r[2] & hs_sync_r[1];
   assign rd_byte    = reg_read(ptr_r);

   // Serial port engine: receive on rising, drive on falling clock
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r   <= S_IDLE;
         bit_cnt_r <= 4'h0;
         shift_r   <= 8'h00;
         ptr_r     <= 8'h00;
         mack_r    <= 1'b0;
         sda_oe_r  <= 1'b0;
         sda_out_r <= 1'b0;
         wr_stb_r  <= 1'b0;
         wr_addr_r <= 8'h00;
         wr_data_r <= 8'h00;
      end else begin
         wr_stb_r <= 1'b0;
         if (start_cond) begin
            state_r   <= S_ADDR;
            bit_cnt_r <= 4'h0;
            sda_oe_r  <= 1'b0;
         end else if (stop_cond) begin
            state_r  <= S_IDLE;
            sda_oe_r <= 1'b0;
         end else if (scl_rise) begin
            case (state_r)
               S_ADDR, S_SUB, S_WR: begin
                  shift_r   <= {shift_r[6:0], sda_f_r};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end
               S_RD_ACK: mack_r <= ~sda_f_r;
               default: ;
            endcase
         end else if (scl_fall) begin
            case (state_r)
               S_ADDR: begin
                  if (bit_cnt_r == 4'h8) begin
                     if (shift_r[7:1] == DEVICE_ADDR) begin
                        sda_oe_r <= 1'b1;
                        mack_r   <= shift_r[0];
                        state_r  <= S_ADDR_ACK;
                     end else begin
                        state_r <= S_IDLE;
                     end
                  end
               end
               S_SUB: begin
                  if (bit_cnt_r == 4'h8) begin
                     ptr_r    <= shift_r;
                     sda_oe_r <= 1'b1;
                     state_r  <= S_SUB_ACK;
                  end
               end
               S_WR: begin
                  if (bit_cnt_r == 4'h8) begin
                     wr_stb_r  <= 1'b1;
                     wr_addr_r <= ptr_r;
                     wr_data_r <= shift_r;
                     ptr_r     <= ptr_r + 8'h01;
                     sda_oe_r  <= 1'b1;
                     state_r   <= S_WR_ACK;
                  end
               end
               S_ADDR_ACK, S_RD_ACK: begin
                  if (mack_r) begin
                     // Read direction or master acked: send next byte
                     shift_r   <= {rd_byte[6:0], 1'b0};
                     sda_oe_r  <= ~rd_byte[7];
                     ptr_r     <= ptr_r + 8'h01;
                     bit_cnt_r <= 4'h1;
                     state_r   <= S_RD;
                  end else begin
                     sda_oe_r  <= 1'b0;
                     bit_cnt_r <= 4'h0;
                     state_r   <= (state_r == S_ADDR_ACK) ? S_SUB : S_IDLE;
                  end
               end
               S_SUB_ACK, S_WR_ACK: begin
                  sda_oe_r  <= 1'b0;
                  bit_cnt_r <= 4'h0;
                  state_r   <= S_WR;
               end
               S_RD: begin
                  if (bit_cnt_r == 4'h8) begin
                     sda_oe_r <= 1'b0;
                     state_r  <= S_RD_ACK;
                  end else begin
                     sda_oe_r  <= ~shift_r[7];
                     shift_r   <= {shift_r[6:0], 1'b0};
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end
               end
               default: state_r <= S_IDLE;
            endcase
         end
      end
   end

   // Register writes; the ratio loads only on a lower-part write
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         upper_stage_r  <= `DIVIDE_RATIO_UPPER_RST;
         lower_nibble_r <= `DIVIDE_RATIO_LOWER_RST;
         ratio_r        <= {`DIVIDE_RATIO_UPPER_RST,
                            `DIVIDE_RATIO_LOWER_RST};
         range_r        <= `RANGE_RST;
         clkgen_other_r <= `CLKGEN_OTHER_RST;
      end else if (wr_stb_r) begin
         case (wr_addr_r)
            `REG_DIVIDE_RATIO_UPPER: upper_stage_r <= wr_data_r;
            `REG_DIVIDE_RATIO_LOWER: begin
               lower_nibble_r <=
                  wr_data_r[`LOWER_NIBBLE_MSB:`LOWER_NIBBLE_LSB];
               ratio_r <= {upper_stage_r,
                  wr_data_r[`LOWER_NIBBLE_MSB:`LOWER_NIBBLE_LSB]};
            end
            `REG_CLOCK_GENERATOR_CTRL: begin
               range_r <= wr_data_r[`RANGE_MSB:`RANGE_LSB];
               clkgen_other_r <=
                  wr_data_r[`CLKGEN_OTHER_MSB:`CLKGEN_OTHER_LSB];
            end
            default: ;
         endcase
      end
   end

   // Post-divider follows the oscillator range
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         post_div_r <= `POST_DIV_BY2;
      end else begin
         case (range_r)
            `RANGE_12_30:  post_div_r <= `POST_DIV_BY4;
            `RANGE_30_60:  post_div_r <= `POST_DIV_BY2;
            default:       post_div_r <= `POST_DIV_BY1;
         endcase
      end
   end

   // Fractional tick generator: ratio ticks per measured line period
   assign acc_sum = acc_r + {{(PERIOD_W-11){1'b0}}, ratio_r};

   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         period_cnt_r  <= {PERIOD_W{1'b0}};
         line_period_r <= {PERIOD_W{1'b0}};
         acc_r         <= {(PERIOD_W+1){1'b0}};
         tick_cnt_r    <= 12'h000;
         tick_r        <= 1'b0;
         locked_r      <= 1'b0;
      end else if (hs_rise) begin
         // Line start realigns phase to the sync edge
         line_period_r <= period_cnt_r + {{(PERIOD_W-1){1'b0}}, 1'b1};
         period_cnt_r  <= {PERIOD_W{1'b0}};
         acc_r         <= {(PERIOD_W+1){1'b0}};
         // Spread ticks exclude the sync tick, so a full line is ratio-1
         locked_r      <= (tick_cnt_r == ratio_r - 12'h001);
         tick_cnt_r    <= 12'h000;
         tick_r        <= 1'b1;
      end else begin
         if (~&period_cnt_r)
            period_cnt_r <= period_cnt_r + {{(PERIOD_W-1){1'b0}}, 1'b1};
         if ((line_period_r != {PERIOD_W{1'b0}}) &&
             (acc_sum >= {1'b0, line_period_r}) &&
             (tick_cnt_r < ratio_r - 12'h001)) begin
            acc_r      <= acc_sum - {1'b0, line_period_r};
            tick_cnt_r <= tick_cnt_r + 12'h001;
            tick_r     <= 1'b1;
         end else begin
            acc_r  <= acc_sum;
            tick_r <= 1'b0;
         end
      end
   end

   // Outputs straight from flops
   assign sda_out                     = sda_out_r;
   assign sda_oe_out                  = sda_oe_r;
   assign line_divide_ratio_out       = ratio_r;
   assign oscillator_range_select_out = range_r;
   assign post_divider_select_out     = post_div_r;
   assign pixel_tick_out              = tick_r;
   assign line_locked_out             = locked_r;

endmodule // pll_divider_control

`default_nettype wire

/* File: pll_divider_control_asserts.sv */
// Port assertions for the pixel clock control block
`timescale 1ns/1ps
`include "pll_divider_control_defines.vh"
`default_nettype none
module pll_divider_control_asserts (
   // Clock and reset
   input wire logic        sys_clk_in,
   input wire logic        rst_n_in,
   // Serial port and sync pins
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        sda_out,
   input wire logic        sda_oe_out,
   input wire logic        hsync_in,
   // Clock generator controls
   input wire logic [11:0] line_divide_ratio_out,
   input wire logic [1:0]  oscillator_range_select_out,
   input wire logic [1:0]  post_divider_select_out,
   input wire logic        pixel_tick_out,
   input wire logic        line_locked_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   // Line start and the tick that answers it
   sequence s_line_start; $rose(hsync_in); endsequence
   sequence s_sync_tick; ##[2:8] pixel_tick_out; endsequence
   property p_tick; s_line_start |-> s_sync_tick; endproperty
   // Post-divider is registered one clock behind the range field
   property p_post;
      $past(oscillator_range_select_out) == `RANGE_12_30 ?
         post_divider_select_out == `POST_DIV_BY4 :
      $past(oscillator_range_select_out) == `RANGE_30_60 ?
         post_divider_select_out == `POST_DIV_BY2 :
         post_divider_select_out == `POST_DIV_BY1;
   endproperty
   property p_ratio_hold;
      $changed(line_divide_ratio_out) |-> !scl_in && !$past(scl_in);
   endproperty
   property p_reset;
      rst_n_in && !$past(rst_n_in) |-> line_divide_ratio_out == 12'h69D
         && oscillator_range_select_out == 2'h1;
   endproperty
   property p_locked; $changed(line_locked_out) |-> hsync_in; endproperty
   property p_oe_change; $changed(sda_oe_out) |-> !scl_in; endproperty
   property p_ack_hold; $rose(sda_oe_out) |-> !scl_in [*3]; endproperty
   property p_sda_zero; sda_out == 1'b0; endproperty
   // Checks on the generator and on the serial port
   a_tick: assert property (p_tick) else $error("no sync tick");
   a_post: assert property (p_post) else $error("bad post div");
   a_ratio_hold: assert property (p_ratio_hold)
      else $error("ratio moved outside load");
   a_reset: assert property (p_reset) else $error("bad reset");
   a_locked: assert property (p_locked) else $error("lock moved");
   a_oe_change: assert property (p_oe_change)
      else $error("sda drive moved with scl high");
   a_ack_hold: assert property (p_ack_hold) else $error("short drive");
   a_sda_zero: assert property (p_sda_zero) else $error("sda high");
endmodule // pll_divider_control_asserts
bind pll_divider_control pll_divider_control_asserts u_asserts (
   .sys_clk_in                  (sys_clk_in),
   .rst_n_in                    (rst_n_in),
   .scl_in                      (scl_in),
   .sda_in                      (sda_in),
   .sda_out                     (sda_out),
   .sda_oe_out                  (sda_oe_out),
   .hsync_in                    (hsync_in),
   .line_divide_ratio_out       (line_divide_ratio_out),
   .oscillator_range_select_out (oscillator_range_select_out),
   .post_divider_select_out     (post_divider_select_out),
   .pixel_tick_out              (pixel_tick_out),
   .line_locked_out             (line_locked_out));
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the pixel clock control block
`timescale 1ns/1ps
`include "pll_divider_control_defines.vh"
`default_nettype none
module tb_top;
   typedef struct packed {
      logic        wr;
      logic [7:0]  a;
      logic [7:0]  d;
      logic [7:0]  q;
      logic [11:0] r;
      logic [1:0]  g;
   } row_t;
   logic        sys_clk_in = 1'b0;
   logic        rst_n_in   = 1'b0;
   logic        scl_in     = 1'b1;
   logic        sda_in     = 1'b1;
   logic        hsync_in   = 1'b0;
   logic        sda_m      = 1'b1;
   logic        s;
   logic [7:0]  q;
   wire         sda_out;
   wire         sda_oe_out;
   wire         tick;
   wire         locked;
   wire  [11:0] ratio;
   wire  [1:0]  rng;
   wire  [1:0]  pdiv;
   wire         sda_w = sda_m & ~sda_oe_out;
   int          failures = 0;
   int          checks_done = 0;
   int          cyc = 0;
   int          tick_cnt = 0;
   int          last_cnt = 0;
   int          n;
   // Reads after reset, then writes, read-only and unmapped places
   row_t rows [0:11] = '{
      '{1'b0, 8'h01, 8'h00, 8'h69, 12'h69D, 2'h1},
      '{1'b0, 8'h02, 8'h00, 8'hD0, 12'h69D, 2'h1},
      '{1'b0, 8'h03, 8'h00, 8'h48, 12'h69D, 2'h1},
      '{1'b1, 8'h01, 8'h12, 8'h12, 12'h69D, 2'h1},
      '{1'b1, 8'h02, 8'hC5, 8'hC0, 12'h12C, 2'h1},
      '{1'b1, 8'h03, 8'h00, 8'h00, 12'h12C, 2'h0},
      '{1'b1, 8'h03, 8'h40, 8'h40, 12'h12C, 2'h1},
      '{1'b1, 8'h03, 8'hBC, 8'hBC, 12'h12C, 2'h2},
      '{1'b1, 8'h03, 8'hFF, 8'hFC, 12'h12C, 2'h3},
      '{1'b1, 8'h00, 8'h55, 8'h00, 12'h12C, 2'h3},
      '{1'b1, 8'h07, 8'h33, 8'h00, 12'h12C, 2'h3},
      '{1'b1, 8'h01, 8'hFF, 8'hFF, 12'h12C, 2'h3}};
   // Device under test
   pll_divider_control dut (
      .sys_clk_in                  (sys_clk_in),
      .rst_n_in                    (rst_n_in),
      .scl_in                      (scl_in),
      .sda_in                      (sda_in),
      .sda_out                     (sda_out),
      .sda_oe_out                  (sda_oe_out),
      .hsync_in                    (hsync_in),
      .line_divide_ratio_out       (ratio),
      .oscillator_range_select_out (rng),
      .post_divider_select_out     (pdiv),
      .pixel_tick_out              (tick),
      .line_locked_out             (locked));
   // 200 MHz clock
   initial begin
      forever #2.5 sys_clk_in = ~sys_clk_in;
   end
   // Wire level, tick count and hang guard
   always @(posedge sys_clk_in) begin
      sda_in <= sda_w;
      if (tick === 1'b1) tick_cnt <= tick_cnt + 1;
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         failures++;
         test_done;
      end
   end
   task automatic hc(input int k);
      repeat (k) @(posedge sys_clk_in);
   endtask
   task automatic chk(input string nm, input logic [11:0] e, g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   function automatic logic [1:0] post(input logic [1:0] g);
      return g == 2'h0 ? `POST_DIV_BY4 : g == 2'h1 ? `POST_DIV_BY2 :
         `POST_DIV_BY1;
   endfunction
   // One serial bit: data set while clock low, sampled while high
   task automatic bit_io(input logic b, output logic v);
      scl_in <= 1'b0;
      hc(2);
      sda_m <= b;
      hc(8);
      scl_in <= 1'b1;
      hc(5);
      v = sda_w;
      hc(5);
   endtask
   task automatic edge2(input logic a, input logic b);
      scl_in <= 1'b0;
      hc(2);
      sda_m <= a;
      hc(8);
      scl_in <= 1'b1;
      hc(10);
      sda_m <= b;
      hc(10);
   endtask
   task automatic put(input logic [7:0] d, input logic ack);
      for (int i = 7; i >= 0; i--) bit_io(d[i], s);
      bit_io(1'b1, s);
      chk("ack", {11'h0, ack}, {11'h0, s});
   endtask
   task automatic reg_wr(input logic [7:0] a, d);
      edge2(1'b1, 1'b0);
      put(8'h98, 1'b0);
      put(a, 1'b0);
      put(d, 1'b0);
      edge2(1'b0, 1'b1);
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      edge2(1'b1, 1'b0);
      put(8'h98, 1'b0);
      put(a, 1'b0);
      edge2(1'b1, 1'b0);
      put(8'h99, 1'b0);
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(1'b1, s);
      edge2(1'b0, 1'b1);
   endtask
   // One 600-cycle line; returns ticks seen over the previous line
   task automatic line(output int k);
      hsync_in <= 1'b1;
      hc(2);
      k = tick_cnt - last_cnt;
      last_cnt = tick_cnt;
      hc(8);
      hsync_in <= 1'b0;
      hc(590);
   endtask
   task automatic test_done;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      hc(12);
      rst_n_in <= 1'b1;
      hc(4);
      foreach (rows[i]) begin
         if (rows[i].wr) reg_wr(rows[i].a, rows[i].d);
         reg_rd(rows[i].a, q);
         chk("reg", {4'h0, rows[i].q}, {4'h0, q});
         chk("ratio", rows[i].r, ratio);
         chk("range", {10'h0, rows[i].g}, {10'h0, rng});
         chk("post", {10'h0, post(rows[i].g)}, {10'h0, pdiv});
      end
      // Foreign device address is left unanswered
      edge2(1'b1, 1'b0);
      put(8'h9A, 1'b1);
      edge2(1'b0, 1'b1);
      // Burst write; upper byte alone keeps the old ratio
      edge2(1'b1, 1'b0);
      put(8'h98, 1'b0);
      put(8'h01, 1'b0);
      put(8'h0D, 1'b0);
      chk("ratio", 12'h12C, ratio);
      put(8'hD0, 1'b0);
      edge2(1'b0, 1'b1);
      chk("ratio", 12'h0DD, ratio);
      repeat (4) line(n);
      chk("ticks", 12'd221, 12'(n));
      chk("locked", 12'h1, {11'h0, locked});
      reg_wr(8'h01, 8'h12);
      reg_wr(8'h02, 8'hC0);
      repeat (4) line(n);
      chk("ticks", 12'd300, 12'(n));
      // Mid-run reset brings back the power-up state
      rst_n_in <= 1'b0;
      hc(2);
      chk("rst ratio", 12'h69D, ratio);
      chk("rst locked", 12'h0, {11'h0, locked});
      rst_n_in <= 1'b1;
      hc(4);
      chk("rst range", {10'h0, `RANGE_RST}, {10'h0, rng});
      chk("rst post", {10'h0, `POST_DIV_BY2}, {10'h0, pdiv});
      reg_rd(8'h01, q);
      chk("rst upper", 12'h069, {4'h0, q});
      test_done;
   end
endmodule // tb_top
`default_nettype wire
